// *** rtl/mfb_decode_defs.svh ***
// Constants for the multifunction board decode and control block.
`ifndef MFB_DECODE_DEFS_SVH
`define MFB_DECODE_DEFS_SVH
// Register byte offsets on the Wishbone bus.
`define MFB_REG_CFG   8'h00
`define MFB_REG_SLU   8'h04
`define MFB_REG_STAT  8'h08
`define MFB_REG_IRQ   8'h0C
`define MFB_REG_MASK  8'h10
// Reset values of the configuration registers.
`define MFB_CFG_RST   18'h3BD02
`define MFB_SLU_RST   12'h56A
`define MFB_IRQ_RST   4'h0
// Decoder input codes: tied low, true bit, complemented bit.
`define MFB_IN_GND    2'h0
`define MFB_IN_TRUE   2'h1
`define MFB_IN_COMP   2'h2
// ROM select sources.
`define MFB_ROM_GND   2'h0
`define MFB_ROM_RANGE 2'h1
`define MFB_ROM_BOOT  2'h2
// Address map pieces, 16-bit addressing.
`define MFB_IO_BANK   3'h7
`define MFB_BANK_1    4'h1
`define MFB_BANK_4    4'h4
`define MFB_ROM_HI    2'h0
`define MFB_BOOT_PAGE 7'h7B
`define MFB_SLU0_MASK 16'hFFE0
`define MFB_SLU0_BASE 16'hFD40
`define MFB_SLU1_MASK 16'hFDC0
`define MFB_SLU1_BASE 16'hFD40
// Timing: clock, refresh penalties (longest figures), line tick.
`define MFB_CLK_HZ     20000000
`define MFB_CLK_NS     50
`define MFB_ARB_MAX_NS 120
`define MFB_REF_MAX_NS 600
`define MFB_ARB_CYC    4'((`MFB_ARB_MAX_NS) / (`MFB_CLK_NS))
`define MFB_REF_CYC    4'((`MFB_REF_MAX_NS) / (`MFB_CLK_NS))
`define MFB_TICK_HZ    60
`define MFB_TICK_HALF  ((`MFB_CLK_HZ) / (2 * (`MFB_TICK_HZ)))
`endif

// *** rtl/mfb_pkg.sv ***
// Types shared by the multifunction board decode and control block.
package mfb_pkg;
  // Configuration register layout.
  typedef struct packed {
    logic       eight1;
    logic       eight0;
    logic [2:0] baud1;
    logic [2:0] baud0;
    logic       clk_opt;
    logic       halt_opt;
    logic       boot_opt;
    logic       ram_32k;
    logic [2:0] ram_bank;
    logic       a13_comp;
    logic [1:0] rom_src;
  } mfb_cfg_type;
  // Serial line decoder input codes.
  typedef struct packed {
    logic [1:0] s1b9;
    logic [1:0] s1b5;
    logic [1:0] s1b4;
    logic [1:0] s1b3;
    logic [1:0] s0b4;
    logic [1:0] s0b3;
  } mfb_slu_type;
  // Latched decoder outputs.
  typedef struct packed {
    logic ram;
    logic rom;
    logic slu0;
    logic slu1;
  } mfb_dec_type;
  // Open-collector pins.
  typedef struct packed {
    logic bus_power_ok;
    logic bus_halt_req;
    logic line_clock_event_req;
    logic framing_err_out;
  } mfb_od_type;
  // Inputs that arrive from outside the clock domain.
  typedef struct packed {
    logic sync;
    logic din;
    logic dout;
    logic init;
    logic pok;
    logic halt;
    logic evnt;
    logic fe;
  } mfb_async_type;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_PEN   = 2'h1,
    ST_REPLY = 2'h3
  } mfb_state_type;
endpackage

// *** rtl/mfb_decode_ctrl.sv ***
// Address decoding, break handling, line tick and refresh reply timing.
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
`include "mfb_decode_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module mfb_decode_ctrl #(
  parameter int unsigned TICK_HALF = `MFB_TICK_HALF
) (
  input  wire logic                mclk,          // System clock, 20 MHz.
  input  wire logic                rstn,          // Asynchronous reset, active low.
  input  wire logic                wb_cyc_i,      // Wishbone cycle.
  input  wire logic                wb_stb_i,      // Wishbone strobe.
  input  wire logic                wb_we_i,       // Wishbone write enable.
  input  wire logic [7:0]          wb_adr_i,      // Wishbone byte address.
  input  wire logic [3:0]          wb_sel_i,      // Wishbone byte lanes.
  input  wire logic [31:0]         wb_dat_i,      // Wishbone write data.
  output logic      [31:0]         wb_dat_o,      // Wishbone read data.
  output logic                     wb_ack_o,      // Wishbone acknowledge.
  input  wire logic [15:0]         bus_addr,      // System bus address.
  input  wire logic                bus_sync,      // Addressing phase marker.
  input  wire logic                bus_din,       // Read data strobe.
  input  wire logic                bus_dout,      // Write data strobe.
  input  wire logic                bus_init,      // Bus initialize.
  input  wire mfb_pkg::mfb_od_type od_i,          // Open-collector pin levels.
  output var  mfb_pkg::mfb_od_type od_o,          // Open-collector pin data.
  output var  mfb_pkg::mfb_od_type od_oe_n,       // Low while pulling a pin.
  input  wire logic                refresh_req,   // Refresh engine request.
  input  wire logic                refresh_busy,  // Refresh cycle in progress.
  input  wire logic                fe_detect,     // Framing error pulse.
  input  wire logic                char_ok,       // Good character pulse.
  output var  mfb_pkg::mfb_dec_type dec_o,        // Latched unit selects.
  output var  mfb_pkg::mfb_cfg_type cfg_o,        // Format and rate selects.
  output logic                     mem_reply,     // Memory reply.
  output logic                     irq            // Interrupt, active high.
);
  import mfb_pkg::*;

  mfb_cfg_type   cfg_reg;
  mfb_slu_type   slu_reg;
  mfb_async_type s1_reg, s2_reg, s3_reg, flt_reg;
  mfb_dec_type   dec_reg;
  mfb_od_type    oe_n_reg;
  mfb_state_type state_reg;
  logic [15:0]   a1_reg, a2_reg, a3_reg, lat_reg;
  logic [3:0]    pen_reg, pen_next, ist_reg, imask_reg, iset;
  logic [17:0]   tick_cnt_reg;
  logic [31:0]   rdat;
  logic          sync_d_reg, fe_reg, tick_reg, tick_d_reg, ack_reg, reply_reg;
  logic          irq_reg, sync_rise, strobe, start, wr;

  // Polarity select for one decoder input.
  function automatic logic pol(input logic [1:0] code, input logic bit_v);
    pol = (code == `MFB_IN_TRUE) ? bit_v : (code == `MFB_IN_COMP) ? ~bit_v : 1'b0;
  endfunction

  // Byte-lane merge for register writes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  // Full decode of one latched address.
  function automatic mfb_dec_type decode(input logic [15:0] a, input mfb_cfg_type c, input mfb_slu_type s);
    logic [3:0] bank;
    logic [3:0] start_b;
    logic       range_hit;
    logic       boot_hit;
    bank      = {1'b0, a[15:13]};
    start_b   = {1'b0, c.ram_bank};
    range_hit = (a[15:14] == `MFB_ROM_HI) && (a[13] == c.a13_comp);
    boot_hit  = (a[15:9] == `MFB_BOOT_PAGE);
    decode.ram = (a[15:13] != `MFB_IO_BANK) && (bank >= start_b)
               && (bank < start_b + (c.ram_32k ? `MFB_BANK_4 : `MFB_BANK_1));
    // ROM and RAM are decoded side by side with no overlay arbitration.
    decode.rom = (c.rom_src == `MFB_ROM_RANGE) ? range_hit
               : (c.rom_src == `MFB_ROM_BOOT) ? boot_hit : 1'b0;
    decode.slu0 = ((a & `MFB_SLU0_MASK) == `MFB_SLU0_BASE)
                && pol(s.s0b3, a[3]) && pol(s.s0b4, a[4]);
    decode.slu1 = ((a & `MFB_SLU1_MASK) == `MFB_SLU1_BASE)
                && pol(s.s1b3, a[3]) && pol(s.s1b4, a[4])
                && pol(s.s1b5, a[5]) && pol(s.s1b9, a[9]);
  endfunction

  // Three-stage synchronisers; a change counts once stages two and three agree.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      flt_reg <= '0;
      a1_reg  <= '0;
      a2_reg  <= '0;
      a3_reg  <= '0;
    end else begin
      s1_reg  <= '{bus_sync, bus_din, bus_dout, bus_init, od_i.bus_power_ok,
                   od_i.bus_halt_req, od_i.line_clock_event_req, od_i.framing_err_out};
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      flt_reg <= mfb_async_type'((s2_reg & s3_reg) | (flt_reg & (s2_reg | s3_reg)));
      a1_reg  <= bus_addr;
      a2_reg  <= a1_reg;
      a3_reg  <= a2_reg;
    end
  end

  assign sync_rise = flt_reg.sync && !sync_d_reg;
  assign strobe    = flt_reg.din || flt_reg.dout;

  // Address latch and decode, held for the whole bus cycle.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync_d_reg <= 1'b0;
      lat_reg    <= '0;
      dec_reg    <= '0;
    end else begin
      sync_d_reg <= flt_reg.sync;
      if (flt_reg.init || !flt_reg.sync) begin
        dec_reg <= '0;
      end else if (sync_rise) begin
        lat_reg <= a3_reg;
        dec_reg <= decode(a3_reg, cfg_reg, slu_reg);
      end
    end
  end

  // Memory reply timing with refresh penalties.
  assign start = (state_reg == ST_IDLE) && strobe && (dec_reg.ram || dec_reg.rom);
  always_comb begin
    pen_next = pen_reg;
    if (start) begin
      pen_next = refresh_busy ? `MFB_REF_CYC : refresh_req ? `MFB_ARB_CYC : '0;
    end else if (state_reg == ST_PEN && pen_reg != '0) begin
      pen_next = pen_reg - 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      pen_reg   <= '0;
      reply_reg <= 1'b0;
    end else begin
      pen_reg <= pen_next;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_PEN;
          end
        end
        ST_PEN: begin
          if (!strobe) begin
            state_reg <= ST_IDLE;
          end else if (pen_reg == '0) begin
            state_reg <= ST_REPLY;
            reply_reg <= 1'b1;
          end
        end
        ST_REPLY: begin
          if (!strobe) begin
            state_reg <= ST_IDLE;
            reply_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          reply_reg <= 1'b0;
        end
      endcase
    end
  end

  // Framing error latch; a new error beats a same-cycle clear.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fe_reg <= 1'b0;
    end else if (fe_detect) begin
      fe_reg <= 1'b1;
    end else if (flt_reg.init || char_ok) begin
      fe_reg <= 1'b0;
    end
  end

  // Line tick: half-period counter; the square wave is slow, so no prescaler.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
      tick_d_reg   <= 1'b0;
    end else begin
      tick_d_reg <= tick_reg;
      if (tick_cnt_reg >= 18'(TICK_HALF - 1)) begin
        tick_cnt_reg <= '0;
        tick_reg     <= ~tick_reg;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 18'h1;
      end
    end
  end

  // Open-collector pulls; data is always low, the enable does the work.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      oe_n_reg <= '1;
    end else begin
      oe_n_reg.bus_power_ok         <= !(fe_reg && cfg_reg.boot_opt);
      oe_n_reg.bus_halt_req         <= !(fe_reg && cfg_reg.halt_opt);
      oe_n_reg.line_clock_event_req <= !(!tick_reg && cfg_reg.clk_opt);
      oe_n_reg.framing_err_out      <= !fe_reg;
    end
  end

  // Wishbone slave: one-cycle registered acknowledge, unmapped reads give zero.
  // The write lands on the edge at which the master samples ack, never before it.
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  always_comb begin
    rdat = '0;
    if (wb_adr_i == `MFB_REG_CFG) begin
      rdat = 32'(cfg_reg);
    end else if (wb_adr_i == `MFB_REG_SLU) begin
      rdat = 32'(slu_reg);
    end else if (wb_adr_i == `MFB_REG_STAT) begin
      rdat = 32'({flt_reg.pok, flt_reg.halt, flt_reg.evnt, flt_reg.fe,
                  state_reg, dec_reg, fe_reg});
    end else if (wb_adr_i == `MFB_REG_IRQ) begin
      rdat = 32'(ist_reg);
    end else if (wb_adr_i == `MFB_REG_MASK) begin
      rdat = 32'(imask_reg);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack_reg  <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ack_reg  <= wb_cyc_i && wb_stb_i && !ack_reg;
      wb_dat_o <= (wb_cyc_i && wb_stb_i && !ack_reg) ? rdat : '0;
    end
  end

  // Configuration registers steer the decoders, pin pulls and interrupt mask.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg   <= `MFB_CFG_RST;
      slu_reg   <= `MFB_SLU_RST;
      imask_reg <= `MFB_IRQ_RST;
    end else if (wr) begin
      if (wb_adr_i == `MFB_REG_CFG) begin
        cfg_reg <= mfb_cfg_type'(18'(merge(32'(cfg_reg), wb_dat_i, wb_sel_i)));
      end else if (wb_adr_i == `MFB_REG_SLU) begin
        slu_reg <= mfb_slu_type'(12'(merge(32'(slu_reg), wb_dat_i, wb_sel_i)));
      end else if (wb_adr_i == `MFB_REG_MASK) begin
        imask_reg <= 4'(merge(32'(imask_reg), wb_dat_i, wb_sel_i));
      end
    end
  end

  // Sticky events: framing error, refresh conflict, bus initialize, tick edge.
  assign iset = {tick_reg && !tick_d_reg, flt_reg.init,
                 start && refresh_busy, fe_detect};
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ist_reg <= `MFB_IRQ_RST;
      irq_reg <= 1'b0;
    end else begin
      if (wr && wb_adr_i == `MFB_REG_IRQ && wb_sel_i[0]) begin
        ist_reg <= (ist_reg & ~wb_dat_i[3:0]) | iset;
      end else begin
        ist_reg <= ist_reg | iset;
      end
      irq_reg <= |(ist_reg & imask_reg);
    end
  end

  assign wb_ack_o  = ack_reg;
  assign od_o      = '0;
  assign od_oe_n   = oe_n_reg;
  assign dec_o     = dec_reg;
  assign cfg_o     = cfg_reg;
  assign mem_reply = reply_reg;
  assign irq       = irq_reg;

  // Checks on the decode, latch and timing behaviour.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_io_page_ram: assert property (dec_reg.ram |-> lat_reg[15:13] != `MFB_IO_BANK)
    else $error("RAM selected in I/O page");
  a_ram_start_bank: assert property (dec_reg.ram |-> lat_reg[15:13] >= cfg_reg.ram_bank)
    else $error("RAM selected below start bank");
  a_rom_gnd_off: assert property (sync_rise && cfg_reg.rom_src == `MFB_ROM_GND |=> !dec_reg.rom)
    else $error("ROM selected while disabled");
  a_rom_bank_bit: assert property (sync_rise && cfg_reg.rom_src == `MFB_ROM_RANGE
                    |=> dec_reg.rom == (lat_reg[15:14] == `MFB_ROM_HI && lat_reg[13] == cfg_reg.a13_comp))
    else $error("ROM bank decode mismatch");
  a_slu1_base: assert property (dec_reg.slu1 |-> (lat_reg & `MFB_SLU1_MASK) == `MFB_SLU1_BASE)
    else $error("Serial line one outside its page");
  a_dec_stable: assert property (flt_reg.sync && sync_d_reg && $past(sync_d_reg) && !flt_reg.init
                  && !$past(flt_reg.init) |-> $stable(dec_reg))
    else $error("Decode changed inside a cycle");
  a_fe_hold: assert property (fe_reg && !flt_reg.init && !char_ok |=> fe_reg)
    else $error("Framing error dropped early");
  a_boot_pull: assert property (fe_reg && cfg_reg.boot_opt |=> !od_oe_n.bus_power_ok)
    else $error("Power-ok not pulled on break");
  a_halt_pull: assert property (fe_reg && cfg_reg.halt_opt |=> !od_oe_n.bus_halt_req)
    else $error("Halt not pulled on break");
  a_arb_delay: assert property (start && !refresh_busy && refresh_req |-> !mem_reply[*3])
    else $error("Reply too early after arbitration");
  a_ref_delay: assert property (start && refresh_busy |-> !mem_reply[*8])
    else $error("Reply too early during refresh");
  a_tick_bound: assert property (tick_cnt_reg < 18'(TICK_HALF))
    else $error("Tick counter out of range");
endmodule // mfb_decode_ctrl
`default_nettype wire

// *** verification/mfb_cpu_model.sv ***
// Processor model that runs system bus cycles against the decode block.
`timescale 1ns/1ps
`default_nettype none
module mfb_cpu_model (
  input  wire logic        mclk,      // System clock.
  input  wire logic        mem_reply, // Reply from memory.
  output logic      [15:0] bus_addr,  // Multiplexed address lines.
  output logic             bus_sync,  // Addressing phase.
  output logic             bus_din,   // Read strobe.
  output logic             bus_dout,  // Write strobe.
  output logic             bus_init   // Bus initialize.
);
  // Idle lines; the address lines float, so they carry a scrambled pattern.
  initial begin
    bus_addr = 16'hA5C3;
    bus_sync = 1'b0;
    bus_din  = 1'b0;
    bus_dout = 1'b0;
    bus_init = 1'b0;
  end
  // Sync rises with the address and stays long enough to pass the input filter.
  task automatic addr_phase(input logic [15:0] a);
    bus_addr <= a;
    bus_sync <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
  // The lines stop carrying the address once the strobe phase starts.
  task automatic data_phase(input logic rd, output int lat);
    bus_addr <= ~bus_addr;
    bus_din  <= rd;
    bus_dout <= ~rd;
    lat = 0;
    @(posedge mclk);
    while (mem_reply !== 1'b1 && lat < 40) begin
      @(posedge mclk);
      lat++;
    end
  endtask
  // Strobes fall first; sync drops only after the reply has gone.
  task automatic end_cycle;
    int n;
    n = 0;
    bus_din  <= 1'b0;
    bus_dout <= 1'b0;
    @(posedge mclk);
    while (mem_reply !== 1'b0 && n < 10) begin
      @(posedge mclk);
      n++;
    end
    bus_sync <= 1'b0;
    bus_addr <= ~bus_addr;
    repeat (8) @(posedge mclk);
  endtask
  // Initialize is held well past the filter so the block surely sees it.
  task automatic init_pulse;
    bus_init <= 1'b1;
    repeat (8) @(posedge mclk);
    bus_init <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
endmodule // mfb_cpu_model
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the decode and control block.
`timescale 1ns/1ps
`default_nettype none
`include "mfb_decode_defs.svh"
module testbench;
  import mfb_pkg::*;
  logic        mclk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [15:0] bus_addr;
  logic        bus_sync, bus_din, bus_dout, bus_init, mem_reply, irq;
  logic        refresh_req, refresh_busy, fe_detect, char_ok;
  mfb_od_type  od_i, od_o, od_oe_n;
  mfb_dec_type dec_o;
  mfb_cfg_type cfg_o, c;
  int          n_fail, cmp_count, cyc_n, l0, l1, l2, n;
  localparam logic [11:0] SLU_D = `MFB_SLU_RST;

  // Pull-ups on every open-collector line; a pin is low only while pulled.
  assign od_i = mfb_od_type'(od_oe_n | od_o);

  mfb_decode_ctrl #(.TICK_HALF(10)) dut_u (.mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .bus_addr(bus_addr), .bus_sync(bus_sync), .bus_din(bus_din), .bus_dout(bus_dout),
    .bus_init(bus_init), .od_i(od_i), .od_o(od_o), .od_oe_n(od_oe_n), .refresh_req(refresh_req),
    .refresh_busy(refresh_busy), .fe_detect(fe_detect), .char_ok(char_ok), .dec_o(dec_o), .cfg_o(cfg_o),
    .mem_reply(mem_reply), .irq(irq));

  mfb_cpu_model cpu_u (.mclk(mclk), .mem_reply(mem_reply), .bus_addr(bus_addr), .bus_sync(bus_sync),
    .bus_din(bus_din), .bus_dout(bus_dout), .bus_init(bus_init));

  // Clock generator, 50 ns period.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask

  // Classic single Wishbone cycle; the request holds until ack is sampled.
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    @(posedge mclk);
    while (wb_ack_o !== 1'b1 && k < 20) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 20) n_fail++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, a, 4'hF, d);
  endtask
  task automatic rd(input logic [7:0] a);
    wb_xfer(1'b0, a, 4'hF, 32'h0);
  endtask

  // Configure, run one bus cycle, and check the selects and whether memory replies.
  task automatic dc(input mfb_cfg_type cf, input logic [11:0] sl, input logic [15:0] a, input logic [3:0] e);
    int lat;
    wr(`MFB_REG_CFG, 32'(cf));
    wr(`MFB_REG_SLU, {20'h0, sl});
    cpu_u.addr_phase(a);
    chk(32'(dec_o), 32'(e), "select");
    cpu_u.data_phase(a[12], lat);
    chk(32'(dec_o), 32'(e), "select held");
    chk(32'(lat < 40), 32'(e[3] | e[2]), "reply");
    cpu_u.end_cycle();
  endtask

  task automatic lat_run(input logic r, input logic b, output int lat);
    refresh_req  <= r;
    refresh_busy <= b;
    cpu_u.addr_phase(16'h1000);
    cpu_u.data_phase(1'b1, lat);
    cpu_u.end_cycle();
    refresh_req  <= 1'b0;
    refresh_busy <= 1'b0;
  endtask

  task automatic rx_pulse(input logic good);
    fe_detect <= ~good;
    char_ok   <= good;
    @(posedge mclk);
    fe_detect <= 1'b0;
    char_ok   <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  // Measures one high and one low stretch of the event pin pull.
  task automatic tick_run(output int hi, output int lo);
    hi = 0;
    lo = 0;
    while (od_oe_n.line_clock_event_req !== 1'b0 && lo < 50) begin
      @(posedge mclk);
      lo++;
    end
    while (od_oe_n.line_clock_event_req !== 1'b1 && hi < 50) begin
      @(posedge mclk);
      hi++;
    end
    hi = 0;
    lo = 0;
    while (od_oe_n.line_clock_event_req === 1'b1 && hi < 50) begin
      @(posedge mclk);
      hi++;
    end
    while (od_oe_n.line_clock_event_req === 1'b0 && lo < 50) begin
      @(posedge mclk);
      lo++;
    end
  endtask

  task automatic end_sim;
    $display("Mismatches %0d, comparisons %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the run needs under two thousand cycles, so this only trips on a hang.
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i, refresh_req, refresh_busy, fe_detect, char_ok} = 8'h0;
    {wb_adr_i, wb_sel_i, wb_dat_i} = 44'h0;
    {n_fail, cmp_count, cyc_n} = 96'h0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chk(32'({cfg_o.eight1, cfg_o.eight0}), 32'h3, "eight bit format");
    chk(32'({cfg_o.baud1, cfg_o.baud0}), 32'h2F, "rate codes");
    rd(`MFB_REG_CFG);
    chk(q, 32'(`MFB_CFG_RST), "cfg reset");
    rd(`MFB_REG_MASK);
    chk(q, 32'h0, "mask reset");
    wb_xfer(1'b1, `MFB_REG_CFG, 4'h0, 32'h3FFFF);
    rd(`MFB_REG_CFG);
    chk(q, 32'(`MFB_CFG_RST), "no lanes");
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20);
    chk(q, 32'h0, "unmapped");
    // Address decode across banks, ROM sources and serial polarity codes.
    c = `MFB_CFG_RST;
    dc(c, SLU_D, 16'h1000, 4'h8);
    dc(c, SLU_D, 16'h2000, 4'h0);
    dc(c, SLU_D, 16'hF600, 4'h4);
    dc(c, SLU_D, 16'hFD40, 4'h2);
    dc(c, SLU_D, 16'hFF70, 4'h1);
    dc(c, 12'h569, 16'hFD48, 4'h2);
    dc(c, 12'h569, 16'hFD40, 4'h0);
    dc(c, 12'h96A, 16'hFD70, 4'h1);
    dc(c, 12'h06A, 16'hFF70, 4'h0);
    dc(c, 12'h562, 16'hFD40, 4'h0);
    c.ram_bank = 3'h3;
    dc(c, SLU_D, 16'h6000, 4'h8);
    dc(c, SLU_D, 16'h4000, 4'h0);
    c.ram_bank = 3'h7;
    dc(c, SLU_D, 16'hE000, 4'h0);
    dc(c, SLU_D, 16'hFD40, 4'h2);
    c.ram_bank = 3'h4;
    c.ram_32k = 1'b1;
    dc(c, SLU_D, 16'h8000, 4'h8);
    dc(c, SLU_D, 16'hE100, 4'h0);
    c.ram_32k = 1'b0;
    c.ram_bank = 3'h2;
    c.rom_src = `MFB_ROM_RANGE;
    dc(c, SLU_D, 16'h0000, 4'h4);
    dc(c, SLU_D, 16'h4000, 4'h8);
    c.a13_comp = 1'b1;
    dc(c, SLU_D, 16'h2000, 4'h4);
    dc(c, SLU_D, 16'h0000, 4'h0);
    c.ram_bank = 3'h1;
    dc(c, SLU_D, 16'h2000, 4'hC);
    c.rom_src = `MFB_ROM_GND;
    dc(c, SLU_D, 16'h2000, 4'h8);
    // Reply delay added by a pending refresh and by one in progress.
    c = `MFB_CFG_RST;
    wr(`MFB_REG_CFG, 32'(c));
    lat_run(1'b0, 1'b0, l0);
    lat_run(1'b1, 1'b0, l1);
    lat_run(1'b0, 1'b1, l2);
    chk(32'(l1 - l0), 32'h2, "arbitration delay");
    chk(32'(l2 - l0), 32'hC, "refresh delay");
    // Break handling with the halt option, then the interrupt path.
    wr(`MFB_REG_IRQ, 32'hF);
    rx_pulse(1'b0);
    chk(32'(od_oe_n), 32'hA, "halt pull");
    repeat (20) @(posedge mclk);
    chk(32'(od_oe_n), 32'hA, "error held");
    chk(32'(irq), 32'h0, "masked");
    wr(`MFB_REG_MASK, 32'h1);
    @(posedge mclk);
    chk(32'(irq), 32'h1, "unmasked");
    rx_pulse(1'b1);
    chk(32'(od_oe_n), 32'hF, "good char clears");
    wr(`MFB_REG_IRQ, 32'h1);
    @(posedge mclk);
    chk(32'(irq), 32'h0, "status cleared");
    // Break handling with the boot option, cleared by bus initialize.
    c.halt_opt = 1'b0;
    c.boot_opt = 1'b1;
    wr(`MFB_REG_CFG, 32'(c));
    rx_pulse(1'b0);
    chk(32'(od_oe_n), 32'h6, "power ok pull");
    cpu_u.init_pulse();
    chk(32'(od_oe_n), 32'hF, "init clears");
    // Line tick on the event pin, then with the option off.
    c.boot_opt = 1'b0;
    c.clk_opt = 1'b1;
    wr(`MFB_REG_CFG, 32'(c));
    tick_run(l0, l1);
    chk(32'(l0), 32'hA, "tick high half");
    chk(32'(l1), 32'hA, "tick low half");
    c.clk_opt = 1'b0;
    wr(`MFB_REG_CFG, 32'(c));
    repeat (3) @(posedge mclk);
    n = 0;
    repeat (25) begin
      @(posedge mclk);
      if (od_oe_n.line_clock_event_req !== 1'b1) n++;
    end
    chk(32'(n), 32'h0, "tick off");
    end_sim();
  end
endmodule // testbench
`default_nettype wire
